// >>> bench/test_trigbit_hit_mask_scalers.sv
// Self-checking bench for the hit-mask, threshold and scaler bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errorCnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module test_trigbit_hit_mask_scalers;
  logic                 clk = 1'h0;
  logic                 rst_n = 1'h0;
  thms_pkg::thms_req_t  req = '0;
  logic [31:0]          rdData;
  logic                 rdValid;
  thms_pkg::thms_hits_t hits;
  logic [2:0]           extDec;
  logic [31:0]          psMasked;
  logic [31:0]          tofMasked;
  thms_pkg::thms_dec_t  dec;
  int                   errorCnt = 0;
  int                   checks = 0;
  int                   cycles = 0;

  always #5 clk = ~clk;

  thms_link_model link (.clk(clk), .hits(hits), .extDec(extDec));
  thms_trigbit_bank dut (
    .clk(clk),
    .rst_n(rst_n),
    .regReq(req),
    .regRdData(rdData),
    .regRdValid(rdValid),
    .hits(hits),
    .barrelModuleCountDecision(extDec[0]),
    .combinedEnergyDecision(extDec[1]),
    .triggerOutputDecision(extDec[2]),
    .pairSpectrometerMasked(psMasked),
    .flightTimeMasked(tofMasked),
    .decisions(dec)
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errorCnt++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    req = '{1'h0 | 1'h1, 1'h0, a, d};
    @(negedge clk);
    req = '0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge clk);
    req = '{1'h0, 1'h1, a, 32'h0};
    @(negedge clk);
    req = '0;
    `CHK(rdValid, 1'h1)
    @(negedge clk);
    `CHK(rdValid, 1'h0)
    d = rdData;
  endtask

  task automatic test_regs();
    logic [15:0] ofs [7] = '{16'h0040, 16'h0050, 16'h0054, 16'h0060, 16'h0064, 16'h0070,
                             16'h0074};
    logic [31:0] expv [7] = '{32'h0000FFFF, 32'hFFFFFFFF, 32'h0000001F, 32'hFFFFFFFF,
                              32'h0000001F, 32'hFFFFFFFF, 32'hFFFFFFFF};
    logic [31:0] d;
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i], d);
      `CHK(d, 32'h0)
      wr(ofs[i], 32'hFFFFFFFF);
      rd(ofs[i], d);
      `CHK(d, expv[i])
    end
    wr(16'h00A0, 32'h12345678);
    rd(16'h00A0, d);
    `CHK(d, 32'h0)
  endtask

  task automatic test_masks();
    wr(16'h0040, 32'h0000FF00);
    wr(16'h0060, 32'hF0F0F0F0);
    wr(16'h0070, 32'h00000001);
    wr(16'h0074, 32'h80000000);
    link.put('{32'hFFFF0F00, 32'h0, 32'hFFFF0000, 32'h2, 32'h7FFFFFFF}, 3'h0);
    @(negedge clk);
    `CHK(psMasked, 32'h00000F00)
    `CHK(tofMasked, 32'hF0F00000)
    `CHK({dec.pairSpectrometer, dec.microscopeTagger, dec.hodoscopeTagger}, 3'h4)
    link.put('{32'h000000FF, 32'h0, 32'h0F0F0F0F, 32'h3, 32'hFFFFFFFF}, 3'h0);
    @(negedge clk);
    `CHK(psMasked | tofMasked, 32'h0)
    `CHK({dec.pairSpectrometer, dec.microscopeTagger, dec.hodoscopeTagger}, 3'h3)
  endtask

  task automatic test_mult();
    wr(16'h0050, 32'h0000000F);
    wr(16'h0054, 32'h00000003);
    wr(16'h0060, 32'hFFFFFFFF);
    wr(16'h0064, 32'h0000001F);
    link.put('{32'h0, 32'h00000107, 32'h7FFFFFFF, 32'h0, 32'h0}, 3'h0);
    @(negedge clk);
    `CHK({dec.startCtrMultiplicity, dec.flightTimeMultiplicity}, 2'h3)
    link.put('{32'h0, 32'h000001F3, 32'h7FFFFFFE, 32'h0, 32'h0}, 3'h0);
    @(negedge clk);
    `CHK({dec.startCtrMultiplicity, dec.flightTimeMultiplicity}, 2'h0)
  endtask

  task automatic test_scalers();
    logic [31:0]          base [8];
    logic [31:0]          b;
    logic [15:0]          ad;
    thms_pkg::thms_hits_t h;
    logic [2:0]           e;
    for (int i = 0; i < 8; i++) begin
      ad = 16'h0080 + 16'(4 * i);
      rd(ad, base[i]);
      wr(ad, 32'h5A5A5A5A);
      rd(ad, b);
      `CHK(b, base[i])
    end
    // Scaler k sees k+1 rising edges, so a swapped index shows as a wrong count.
    for (int k = 0; k < 8; k++) begin
      h = '0;
      e = 3'h0;
      case (k)
        0: e = 3'h1;
        1: e = 3'h2;
        2: h.microscopeTaggerHitVector = 32'h00000001;
        3: h.hodoscopeTaggerHitVector = 32'h80000000;
        4: h.pairSpectrometerHitVector = 32'h00000100;
        5: h.startCtrHitVector = 32'h00000007;
        6: h.flightTimeHitVector = 32'hFFFFFFFF;
        default: e = 3'h4;
      endcase
      repeat (k + 1) begin
        link.put(h, e);
        link.put('0, 3'h0);
      end
    end
    // Counts start undefined, so increments are judged against the baseline.
    for (int i = 0; i < 8; i++) begin
      rd(16'h0080 + 16'(4 * i), b);
      `CHK(b, base[i] + 32'(i + 1))
    end
  endtask

  task automatic test_reset();
    logic [31:0] s;
    logic [31:0] d;
    rd(16'h0094, s);
    @(negedge clk);
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    `CHK({psMasked, tofMasked}, 64'h0)
    `CHK(dec, 5'h0)
    rd(16'h0050, d);
    `CHK(d, 32'h0)
    rd(16'h0064, d);
    `CHK(d, 32'h0)
    // A zero threshold is always met, so the start-counter scaler counts once.
    rd(16'h0094, d);
    `CHK(d, s + 32'h1)
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'h1;
    test_regs();
    $display("done: registers");
    test_masks();
    $display("done: masks");
    test_mult();
    $display("done: multiplicity");
    test_scalers();
    $display("done: scalers");
    test_reset();
    $display("done: reset");
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> bench/thms_asserts.sv
// Port-level assertions for the hit-mask, threshold and scaler bank.
`timescale 1ns/1ps
`default_nettype none
module thms_asserts (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire thms_pkg::thms_req_t  regReq,
  input  wire logic [31:0]          regRdData,
  input  wire logic                 regRdValid,
  input  wire thms_pkg::thms_hits_t hits,
  input  wire logic [31:0]          pairSpectrometerMasked,
  input  wire logic [31:0]          flightTimeMasked,
  input  wire thms_pkg::thms_dec_t  decisions
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ps_mask_a: assert property (
    (pairSpectrometerMasked & ~$past(hits.pairSpectrometerHitVector)) == 32'h0)
    else $error("Masked pair bits without hits.");
  tof_mask_a: assert property (
    (flightTimeMasked & ~$past(hits.flightTimeHitVector)) == 32'h0)
    else $error("Masked flight bits without hits.");
  ps_or_a: assert property (
    decisions.pairSpectrometer == (|pairSpectrometerMasked))
    else $error("Pair decision differs from masked pattern.");
  tagm_or_a: assert property (
    decisions.microscopeTagger |-> $past(hits.microscopeTaggerHitVector) != 32'h0)
    else $error("Microscope decision with no hits.");
  tagh_or_a: assert property (
    decisions.hodoscopeTagger |-> $past(hits.hodoscopeTaggerHitVector) != 32'h0)
    else $error("Hodoscope decision with no hits.");
  read_pulse_a: assert property (
    regRdValid == $past(regReq.rdEn))
    else $error("Read valid not one cycle after read.");
  limit_width_a: assert property (
    regRdValid && ($past(regReq.addr) inside {16'h0054, 16'h0064}) |-> regRdData[31:5] == 27'h0)
    else $error("Threshold upper bits not zero.");
  array_end_a: assert property (
    regRdValid && $past(regReq.addr) == 16'h00A0 |-> regRdData == 32'h0)
    else $error("Read past last scaler not zero.");
endmodule
bind thms_trigbit_bank thms_asserts chk (
  .clk(clk),
  .rst_n(rst_n),
  .regReq(regReq),
  .regRdData(regRdData),
  .regRdValid(regRdValid),
  .hits(hits),
  .pairSpectrometerMasked(pairSpectrometerMasked),
  .flightTimeMasked(flightTimeMasked),
  .decisions(decisions)
);
`default_nettype wire

// >>> bench/thms_link_model.sv
// Upstream trigger-link model that drives hit vectors and external decision levels.
`timescale 1ns/1ps
`default_nettype none
module thms_link_model (
  input  wire logic                 clk,
  output var  thms_pkg::thms_hits_t hits,
  output var  logic [2:0]           extDec
);
  initial begin
    hits = '0;
    extDec = 3'h0;
  end

  // New levels land just after a falling edge, clear of the sampling edge.
  task automatic put(input thms_pkg::thms_hits_t h, input logic [2:0] e);
    @(negedge clk);
    hits = h;
    extDec = e;
  endtask
endmodule
`default_nettype wire

// >>> rtl/thms_edge_counter.sv
// Counter that advances once on each rising edge of a decision level seen while rst_n is high.
`timescale 1ns/1ps
`default_nettype none
module thms_edge_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             decision,
  output var  logic [WIDTH-1:0] count
);
  logic             decisionDly_r;
  // RULE13: count survives reset
  // The start value is only a power-up value, and reset leaves the count alone.
  // Software therefore reads a baseline and works by difference.
  logic [WIDTH-1:0] count_r = '0;

  if (WIDTH < 1) begin : gWidthCheck
    $error("thms_edge_counter: WIDTH must be positive");
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      decisionDly_r <= 1'b0;
    end else begin
      decisionDly_r <= decision;
    end
  end

  // RULE14: count rising edges
  always_ff @(posedge clk) begin
    if (rst_n && decision && !decisionDly_r) begin
      count_r <= count_r + WIDTH'(1);
    end
  end

  assign count = count_r;
endmodule
`default_nettype wire

// >>> rtl/thms_pkg.sv
// Package with register map, field layouts and carrier types of the hit-mask and scaler bank.
package thms_pkg;
  localparam int          DATA_W            = 32;
  localparam int          ADDR_W            = 16;
  localparam int          NUM_SCALERS       = 8;
  localparam int          SCALER_IDX_W      = 3;
  localparam int          STRIDE_BYTES      = 4;
  localparam int          THR_W             = 5;
  localparam logic [15:0] PS_MASK_OFS       = 16'h0040;
  localparam logic [15:0] ST_MASK_OFS       = 16'h0050;
  localparam logic [15:0] ST_LIMIT_OFS      = 16'h0054;
  localparam logic [15:0] TOF_MASK_OFS      = 16'h0060;
  localparam logic [15:0] TOF_LIMIT_OFS     = 16'h0064;
  localparam logic [15:0] TAGM_MASK_OFS     = 16'h0070;
  localparam logic [15:0] TAGH_MASK_OFS     = 16'h0074;
  localparam logic [15:0] SCALER_BASE_OFS   = 16'h0080;
  localparam logic [15:0] PS_MASK_FIELD     = 16'hFFFF;
  localparam logic [31:0] REG_RESET         = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ     = 32'h00000000;
  localparam int          SC_BCAL           = 0;
  localparam int          SC_BFCAL          = 1;
  localparam int          SC_TAGM           = 2;
  localparam int          SC_TAGH           = 3;
  localparam int          SC_PS             = 4;
  localparam int          SC_ST             = 5;
  localparam int          SC_TOF            = 6;
  localparam int          SC_TRIGOUT        = 7;

  typedef struct packed {
    logic [31:0] pairSpectrometerHitVector;
    logic [31:0] startCtrHitVector;
    logic [31:0] flightTimeHitVector;
    logic [31:0] microscopeTaggerHitVector;
    logic [31:0] hodoscopeTaggerHitVector;
  } thms_hits_t;

  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [15:0] addr;
    logic [31:0] wrData;
  } thms_req_t;

  typedef struct packed {
    logic        pairSpectrometer;
    logic        startCtrMultiplicity;
    logic        flightTimeMultiplicity;
    logic        microscopeTagger;
    logic        hodoscopeTagger;
  } thms_dec_t;
endpackage

// >>> rtl/thms_trigbit_bank.sv
// Hit-pattern masks, hit-count thresholds, decisions and the read-only scaler bank.
// Function
// RULE1: pair-spectrometer hits ANDed with their mask before coincidence logic.
// RULE2: start-counter hits ANDed with their mask before multiplicity logic.
// RULE3: start-counter decision compares masked hit count with its threshold.
// RULE4: flight-time hits ANDed with their mask before multiplicity and coincidence.
// RULE5: flight-time decision compares masked hit count with its threshold.
// RULE6: microscope-tagger hits ANDed with their mask.
// RULE7: microscope-tagger decision is OR of all masked bits.
// RULE8: hodoscope-tagger hits ANDed with their mask.
// RULE9: hodoscope-tagger decision is OR of all masked bits.
// RULE10: scalers read-only 32-bit counts; writes leave them unchanged.
// RULE11: scalers start at base offset, one word apart, index order.
// RULE12: scaler indices 0..7 map barrel, energy, tagM, tagH, PS, ST, TOF, output.
// RULE13: scaler contents are undefined after reset.
// RULE14: multiplicity true when count >= threshold; scalers count rising edges.
`timescale 1ns/1ps
`default_nettype none
module thms_trigbit_bank #(
  parameter int HIT_W = 32
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire thms_pkg::thms_req_t  regReq,
  output var  logic [31:0]          regRdData,
  output var  logic                 regRdValid,
  input  wire thms_pkg::thms_hits_t hits,
  input  wire logic                 barrelModuleCountDecision,
  input  wire logic                 combinedEnergyDecision,
  input  wire logic                 triggerOutputDecision,
  output var  logic [31:0]          pairSpectrometerMasked,
  output var  logic [31:0]          flightTimeMasked,
  output var  thms_pkg::thms_dec_t  decisions
);
  localparam int CNT_W = $clog2(HIT_W + 1);

  logic [31:0] pairSpectrometerMask_r;
  logic [31:0] startCtrHitMask_r;
  logic [31:0] startCtrCountLimit_r;
  logic [31:0] flightTimeHitMask_r;
  logic [31:0] flightTimeCountLimit_r;
  logic [31:0] microscopeTaggerMask_r;
  logic [31:0] hodoscopeTaggerMask_r;
  logic [31:0] startCtrMaskedVec;
  logic [31:0] flightTimeMaskedVec;
  logic [31:0] microscopeMaskedVec;
  logic [31:0] hodoscopeMaskedVec;
  logic [31:0] pairMaskedVec;
  logic [CNT_W-1:0] startCtrMultiplicity;
  logic [CNT_W-1:0] flightTimeMultiplicity;
  logic [thms_pkg::THR_W-1:0] startCtrCountThreshold;
  logic [thms_pkg::THR_W-1:0] flightTimeCountThreshold;
  logic [thms_pkg::NUM_SCALERS-1:0] scalerDecision;
  logic [31:0] scalerCount [thms_pkg::NUM_SCALERS];
  logic [31:0] rdData_nxt;
  logic        scalerHit;
  logic [15:0] scalerOfs;
  logic [thms_pkg::SCALER_IDX_W-1:0] scalerIdx;

  if (HIT_W != thms_pkg::DATA_W) begin : gHitWidthCheck
    $error("thms_trigbit_bank: HIT_W must equal the 32-bit register width");
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pairSpectrometerMask_r <= thms_pkg::REG_RESET;
      startCtrHitMask_r      <= thms_pkg::REG_RESET;
      startCtrCountLimit_r   <= thms_pkg::REG_RESET;
      flightTimeHitMask_r    <= thms_pkg::REG_RESET;
      flightTimeCountLimit_r <= thms_pkg::REG_RESET;
      microscopeTaggerMask_r <= thms_pkg::REG_RESET;
      hodoscopeTaggerMask_r  <= thms_pkg::REG_RESET;
    end else if (regReq.wrEn) begin
      // RULE10: scaler writes ignored
      unique case (regReq.addr)
        thms_pkg::PS_MASK_OFS:   pairSpectrometerMask_r <= regReq.wrData & 32'(thms_pkg::PS_MASK_FIELD);
        thms_pkg::ST_MASK_OFS:   startCtrHitMask_r      <= regReq.wrData;
        thms_pkg::ST_LIMIT_OFS:  startCtrCountLimit_r   <= 32'(regReq.wrData[thms_pkg::THR_W-1:0]);
        thms_pkg::TOF_MASK_OFS:  flightTimeHitMask_r    <= regReq.wrData;
        thms_pkg::TOF_LIMIT_OFS: flightTimeCountLimit_r <= 32'(regReq.wrData[thms_pkg::THR_W-1:0]);
        thms_pkg::TAGM_MASK_OFS: microscopeTaggerMask_r <= regReq.wrData;
        thms_pkg::TAGH_MASK_OFS: hodoscopeTaggerMask_r  <= regReq.wrData;
        default: begin
        end
      endcase
    end
  end

  // RULE1: pair-spectrometer masking
  assign pairMaskedVec = hits.pairSpectrometerHitVector & pairSpectrometerMask_r;
  // RULE2: start-counter masking
  assign startCtrMaskedVec = hits.startCtrHitVector & startCtrHitMask_r;
  // RULE4: flight-time masking
  assign flightTimeMaskedVec = hits.flightTimeHitVector & flightTimeHitMask_r;
  // RULE6: microscope-tagger masking
  assign microscopeMaskedVec = hits.microscopeTaggerHitVector & microscopeTaggerMask_r;
  // RULE8: hodoscope-tagger masking
  assign hodoscopeMaskedVec = hits.hodoscopeTaggerHitVector & hodoscopeTaggerMask_r;

  assign startCtrCountThreshold   = startCtrCountLimit_r[thms_pkg::THR_W-1:0];
  assign flightTimeCountThreshold = flightTimeCountLimit_r[thms_pkg::THR_W-1:0];

  always_comb begin
    startCtrMultiplicity   = '0;
    flightTimeMultiplicity = '0;
    for (int i = 0; i < HIT_W; i++) begin
      startCtrMultiplicity   = startCtrMultiplicity + CNT_W'(startCtrMaskedVec[i]);
      flightTimeMultiplicity = flightTimeMultiplicity + CNT_W'(flightTimeMaskedVec[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      decisions              <= '0;
      pairSpectrometerMasked <= thms_pkg::REG_RESET;
      flightTimeMasked       <= thms_pkg::REG_RESET;
    end else begin
      pairSpectrometerMasked <= pairMaskedVec;
      flightTimeMasked       <= flightTimeMaskedVec;
      decisions.pairSpectrometer <= |pairMaskedVec;
      // RULE14: greater-or-equal compare
      // RULE3: start-counter threshold compare
      decisions.startCtrMultiplicity <=
        startCtrMultiplicity >= CNT_W'(startCtrCountThreshold);
      // RULE5: flight-time threshold compare
      decisions.flightTimeMultiplicity <=
        flightTimeMultiplicity >= CNT_W'(flightTimeCountThreshold);
      // RULE7: microscope OR reduction
      decisions.microscopeTagger <= |microscopeMaskedVec;
      // RULE9: hodoscope OR reduction
      decisions.hodoscopeTagger <= |hodoscopeMaskedVec;
    end
  end

  // RULE12: scaler index assignment
  always_comb begin
    scalerDecision                        = '0;
    scalerDecision[thms_pkg::SC_BCAL]     = barrelModuleCountDecision;
    scalerDecision[thms_pkg::SC_BFCAL]    = combinedEnergyDecision;
    scalerDecision[thms_pkg::SC_TAGM]     = decisions.microscopeTagger;
    scalerDecision[thms_pkg::SC_TAGH]     = decisions.hodoscopeTagger;
    scalerDecision[thms_pkg::SC_PS]       = decisions.pairSpectrometer;
    scalerDecision[thms_pkg::SC_ST]       = decisions.startCtrMultiplicity;
    scalerDecision[thms_pkg::SC_TOF]      = decisions.flightTimeMultiplicity;
    scalerDecision[thms_pkg::SC_TRIGOUT]  = triggerOutputDecision;
  end

  // RULE13: counters not reset
  for (genvar g = 0; g < thms_pkg::NUM_SCALERS; g++) begin : gScaler
    thms_edge_counter #(
      .WIDTH(thms_pkg::DATA_W)
    ) uCounter (
      .clk      (clk),
      .rst_n    (rst_n),
      .decision (scalerDecision[g]),
      .count    (scalerCount[g])
    );
  end

  // RULE11: scaler word decode
  assign scalerOfs = regReq.addr - thms_pkg::SCALER_BASE_OFS;
  assign scalerHit = (regReq.addr >= thms_pkg::SCALER_BASE_OFS) &&
                     (scalerOfs < 16'(thms_pkg::NUM_SCALERS * thms_pkg::STRIDE_BYTES)) &&
                     (scalerOfs[1:0] == 2'h0);
  assign scalerIdx = scalerOfs[thms_pkg::SCALER_IDX_W+1:2];

  always_comb begin
    rdData_nxt = thms_pkg::UNMAPPED_READ;
    if (scalerHit) begin
      rdData_nxt = scalerCount[scalerIdx];
    end else begin
      unique case (regReq.addr)
        thms_pkg::PS_MASK_OFS:   rdData_nxt = pairSpectrometerMask_r;
        thms_pkg::ST_MASK_OFS:   rdData_nxt = startCtrHitMask_r;
        thms_pkg::ST_LIMIT_OFS:  rdData_nxt = startCtrCountLimit_r;
        thms_pkg::TOF_MASK_OFS:  rdData_nxt = flightTimeHitMask_r;
        thms_pkg::TOF_LIMIT_OFS: rdData_nxt = flightTimeCountLimit_r;
        thms_pkg::TAGM_MASK_OFS: rdData_nxt = microscopeTaggerMask_r;
        thms_pkg::TAGH_MASK_OFS: rdData_nxt = hodoscopeTaggerMask_r;
        default:                 rdData_nxt = thms_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData  <= thms_pkg::UNMAPPED_READ;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regReq.rdEn;
      if (regReq.rdEn) begin
        regRdData <= rdData_nxt;
      end
    end
  end
endmodule
`default_nettype wire
